// [hdl/rdb_controller.sv]
// Purpose: memory controller end, queues command words onto the link
// Assumes: software port on mclk, read data one cycle after strobe
// Notes:   FIFO full refuses writes and counts them
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rdb_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 16
) (
  // clock, reset, enable
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wrPtr;
    logic [PW:0]                 rdPtr;
  } rdb_fifo_state_t;
  rdb_fifo_state_t st;
  rdb_fifo_state_t next_st;
  logic            empty;
  logic            full;

  assign empty = (st.wrPtr == st.rdPtr);
  assign full  = (st.wrPtr[PW] != st.rdPtr[PW]) &&
                 (st.wrPtr[PW-1:0] == st.rdPtr[PW-1:0]);
  // ready and valid are forced low while the clock enable is low
  assign inReady  = ce & ~full;
  assign outValid = ce & ~empty;
  assign outData  = st.mem[st.rdPtr[PW-1:0]];

  always_comb begin
    next_st = st;
    if (inValid && inReady) begin
      next_st.mem[st.wrPtr[PW-1:0]] = inData;
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (outValid && outReady) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

module rdb_controller (
  // clock, reset, enable
  input  wire logic                         mclk,
  input  wire logic                         arst_n,
  input  wire logic                         ce,
  // software register port
  input  wire logic [rdb_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [rdb_pkg::REG_W-1:0]    regWrData,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic      [rdb_pkg::REG_W-1:0]    regRdData,
  // link to the buffer
  rdb_link_if.ctl                           link
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [3:0]                  ctrl;
    logic [rdb_pkg::CMD_W-1:0]   idle;
    logic [rdb_pkg::DROP_W-1:0]  drops;
    logic [rdb_pkg::REG_W-1:0]   rdData;
    logic [rdb_pkg::CMD_W-1:0]   word;
    logic                        width;
    logic                        variant;
    logic                        bufResetN;
  } rdb_ctl_state_t;
  rdb_ctl_state_t st;
  rdb_ctl_state_t next_st;

  logic                      pushValid;
  logic                      pushReady;
  logic                      popValid;
  logic                      popReady;
  logic [rdb_pkg::CMD_W-1:0] popData;

  assign pushValid = regWr && (regAddr == rdb_pkg::OFS_DATA);
  // drain stalls unless running, so the queue can really fill
  assign popReady  = st.ctrl[rdb_pkg::CTRL_RUN_BIT];

  rdb_fifo #(
    .WIDTH (rdb_pkg::CMD_W),
    .DEPTH (rdb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .ce       (ce),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (regWrData[rdb_pkg::CMD_W-1:0]),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popData)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    if (regWr && (regAddr == rdb_pkg::OFS_CTRL)) begin
      next_st.ctrl = regWrData[3:0];
    end
    if (regWr && (regAddr == rdb_pkg::OFS_IDLE)) begin
      next_st.idle = regWrData[rdb_pkg::CMD_W-1:0];
    end
    if (pushValid && !pushReady && (st.drops != '1)) begin
      next_st.drops = st.drops + 1'b1;
    end
    next_st.rdData = '0;
    if (regRd) begin
      unique case (regAddr)
        rdb_pkg::OFS_CTRL:   next_st.rdData[3:0] = st.ctrl;
        rdb_pkg::OFS_IDLE:   next_st.rdData[rdb_pkg::CMD_W-1:0] = st.idle;
        rdb_pkg::OFS_STATUS: begin
          next_st.rdData[rdb_pkg::STAT_EMPTY_BIT] = ~popValid;
          next_st.rdData[rdb_pkg::STAT_FULL_BIT]  = ~pushReady;
          next_st.rdData[rdb_pkg::STAT_DROP_LSB +: rdb_pkg::DROP_W] =
            st.drops;
        end
        rdb_pkg::OFS_OBS_A:
          next_st.rdData[rdb_pkg::DATA_W-1:0] = link.registeredOutputs;
        rdb_pkg::OFS_OBS_B: begin
          next_st.rdData[rdb_pkg::HALF_W-1:0] = link.registeredOutputsB;
          next_st.rdData[rdb_pkg::HALF_W +: 6] = {
            link.ckeCopyBOut, link.ckeCopyAOut,
            link.terminationCopyBOut, link.terminationCopyAOut,
            link.selectCopyBOut, link.selectCopyAOut};
        end
        default: next_st.rdData = '0;
      endcase
    end
    // an empty queue sends the idle word, selects high holds data
    next_st.word = (popValid && popReady) ? popData : st.idle;
    next_st.width = st.ctrl[rdb_pkg::CTRL_WIDTH_BIT];
    // variant only ever driven high together with width
    next_st.variant = st.ctrl[rdb_pkg::CTRL_VARIANT_BIT] &
                      st.ctrl[rdb_pkg::CTRL_WIDTH_BIT];
    // buffer stays in reset until software releases it
    next_st.bufResetN = st.ctrl[rdb_pkg::CTRL_RELEASE_BIT];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st      <= '0;
      st.ctrl <= rdb_pkg::CTRL_RESET;
      st.idle <= rdb_pkg::IDLE_RESET;
      // link idles with both selects high from the very start
      st.word <= rdb_pkg::IDLE_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs, all from flops and always defined
  // ****************************************
  assign regRdData              = st.rdData;
  assign link.gatedDataInputs   = st.word[rdb_pkg::DATA_W-1:0];
  assign link.primarySelectN    = st.word[rdb_pkg::WORD_PSEL_BIT];
  assign link.secondarySelectN  = st.word[rdb_pkg::WORD_SSEL_BIT];
  assign link.terminationCtrlIn = st.word[rdb_pkg::WORD_TERM_BIT];
  assign link.clockEnableCtrlIn = st.word[rdb_pkg::WORD_CKE_BIT];
  assign link.widthModeSel      = st.width;
  assign link.pinoutVariantSel  = st.variant;
  assign link.bufResetN         = st.bufResetN;
endmodule
`default_nettype wire

// [pkg/rdb_pkg.sv]
// Purpose: shared constants and types of the registered buffer link
// Assumes: one clock, mclk at 40 MHz
// Notes:   word layout is shared by controller FIFO and link drive
`default_nettype none
package rdb_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int DATA_W     = 25;
  localparam int HALF_W     = 14;
  localparam int VARB_LSB   = 11;
  localparam int CMD_W      = 29;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W     = 8;
  localparam int REG_W      = 32;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int RX_ENABLE_NS  = 200;
  // least time, rounded up to whole cycles
  localparam int RX_WAIT_CYCLES =
    (RX_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RX_CNT_W = 4;

  // ****************************************
  // command word fields
  // ****************************************
  localparam int WORD_PSEL_BIT = 25;
  localparam int WORD_SSEL_BIT = 26;
  localparam int WORD_TERM_BIT = 27;
  localparam int WORD_CKE_BIT  = 28;

  // ****************************************
  // controller register map
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IDLE   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_OBS_A  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OBS_B  = 8'h14;

  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_WIDTH_BIT   = 1;
  localparam int CTRL_VARIANT_BIT = 2;
  localparam int CTRL_RELEASE_BIT = 3;

  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT  = 1;
  localparam int STAT_DROP_LSB  = 8;
  localparam int DROP_W         = 8;

  localparam logic [3:0]       CTRL_RESET = 4'h0;
  localparam logic [CMD_W-1:0] IDLE_RESET = 29'h06000000;

  // ****************************************
  // buffer state
  // ****************************************
  typedef struct packed {
    logic [RX_CNT_W-1:0] rxWait;
    logic [DATA_W-1:0]   outA;
    logic [HALF_W-1:0]   outB;
    logic                selA;
    logic                selB;
    logic                termA;
    logic                termB;
    logic                ckeA;
    logic                ckeB;
  } rdb_buf_state_t;
endpackage
`default_nettype wire

// [pkg/rdb_link_if.sv]
// Purpose: wires between memory controller and registered buffer
// Assumes: both ends on mclk
// Notes:   no two-way pins
`timescale 1ns/1ps
`default_nettype none
interface rdb_link_if;
  logic [rdb_pkg::DATA_W-1:0] gatedDataInputs;
  logic                       primarySelectN;
  logic                       secondarySelectN;
  logic                       terminationCtrlIn;
  logic                       clockEnableCtrlIn;
  logic                       widthModeSel;
  logic                       pinoutVariantSel;
  logic                       bufResetN;
  logic [rdb_pkg::DATA_W-1:0] registeredOutputs;
  logic [rdb_pkg::HALF_W-1:0] registeredOutputsB;
  logic                       selectCopyAOut;
  logic                       selectCopyBOut;
  logic                       terminationCopyAOut;
  logic                       terminationCopyBOut;
  logic                       ckeCopyAOut;
  logic                       ckeCopyBOut;

  modport dev (
    input  gatedDataInputs, primarySelectN, secondarySelectN,
           terminationCtrlIn, clockEnableCtrlIn, widthModeSel,
           pinoutVariantSel, bufResetN,
    output registeredOutputs, registeredOutputsB, selectCopyAOut,
           selectCopyBOut, terminationCopyAOut, terminationCopyBOut,
           ckeCopyAOut, ckeCopyBOut
  );
  modport ctl (
    output gatedDataInputs, primarySelectN, secondarySelectN,
           terminationCtrlIn, clockEnableCtrlIn, widthModeSel,
           pinoutVariantSel, bufResetN,
    input  registeredOutputs, registeredOutputsB, selectCopyAOut,
           selectCopyBOut, terminationCopyAOut, terminationCopyBOut,
           ckeCopyAOut, ckeCopyBOut
  );
endinterface
`default_nettype wire

// [hdl/rdb_buffer.sv]
// Purpose: registered command/address buffer, 25 bit 1:1 or 14 bit 1:2
// Assumes: link inputs come from logic on mclk
// Notes:   receivers modelled as a wake-up counter after reset
`timescale 1ns/1ps
`default_nettype none
module rdb_buffer (
  // clock, reset, enable
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic ce,
  // link to controller and memory devices
  rdb_link_if.dev   link
);
  // ****************************************
  // reset and receiver wake-up
  // ****************************************
  rdb_pkg::rdb_buf_state_t st;
  rdb_pkg::rdb_buf_state_t next_st;

  logic                       rstN;
  logic                       rxOn;
  logic [rdb_pkg::DATA_W-1:0] din;
  logic                       pselN;
  logic                       sselN;
  logic                       term;
  logic                       cke;
  logic                       split;
  logic [rdb_pkg::HALF_W-1:0] halfIn;

  // chip reset or the link reset both clear at once
  assign rstN = arst_n & link.bufResetN;
  assign rxOn = (st.rxWait ==
                 rdb_pkg::RX_CNT_W'(rdb_pkg::RX_WAIT_CYCLES));

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    // register is live at once; receivers come up later
    if (!rxOn) begin
      next_st.rxWait = st.rxWait + 1'b1;
    end
    // disabled receivers read as low, floating inputs harmless
    din   = rxOn ? link.gatedDataInputs : '0;
    pselN = rxOn & link.primarySelectN;
    sselN = rxOn & link.secondarySelectN;
    term  = rxOn & link.terminationCtrlIn;
    cke   = rxOn & link.clockEnableCtrlIn;
    // illegal variant-without-width falls back to 1:1
    split = link.widthModeSel;
    halfIn = (split & link.pinoutVariantSel) ?
             din[rdb_pkg::VARB_LSB +: rdb_pkg::HALF_W] :
             din[rdb_pkg::HALF_W-1:0];
    // gated data bits only move while a select is low
    if (!(pselN & sselN)) begin
      if (split) begin
        next_st.outA = {{(rdb_pkg::DATA_W-rdb_pkg::HALF_W){1'b0}},
                        halfIn};
        next_st.outB = halfIn;
      end else begin
        next_st.outA = din;
        next_st.outB = '0;
      end
    end
    // these copies follow every edge regardless of gating
    next_st.selA  = pselN;
    next_st.selB  = split & pselN;
    next_st.termA = term;
    next_st.termB = split & term;
    next_st.ckeA  = cke;
    next_st.ckeB  = split & cke;
  end

  // ****************************************
  // state register
  // ****************************************
  // async clear puts outputs low before receivers settle
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.registeredOutputs   = st.outA;
  assign link.registeredOutputsB  = st.outB;
  assign link.selectCopyAOut      = st.selA;
  assign link.selectCopyBOut      = st.selB;
  assign link.terminationCopyAOut = st.termA;
  assign link.terminationCopyBOut = st.termB;
  assign link.ckeCopyAOut         = st.ckeA;
  assign link.ckeCopyBOut         = st.ckeB;
endmodule
`default_nettype wire

// [verif/rdb_properties.sv]
// Purpose: link checks between controller end and buffer end
// Assumes: ce high while the wake count matters
// Notes:   live means the receivers are surely awake
`timescale 1ns/1ps
`default_nettype none
module rdb_properties (
  // clock, reset, enable
  input wire logic                       mclk,
  input wire logic                       arst_n,
  input wire logic                       ce,
  // controller to buffer
  input wire logic [rdb_pkg::DATA_W-1:0] gatedDataInputs,
  input wire logic                       primarySelectN,
  input wire logic                       secondarySelectN,
  input wire logic                       terminationCtrlIn,
  input wire logic                       clockEnableCtrlIn,
  input wire logic                       widthModeSel,
  input wire logic                       pinoutVariantSel,
  input wire logic                       bufResetN,
  // buffer to memory devices
  input wire logic [rdb_pkg::DATA_W-1:0] registeredOutputs,
  input wire logic [rdb_pkg::HALF_W-1:0] registeredOutputsB,
  input wire logic                       selectCopyAOut,
  input wire logic                       selectCopyBOut,
  input wire logic                       terminationCopyAOut,
  input wire logic                       terminationCopyBOut,
  input wire logic                       ckeCopyAOut,
  input wire logic                       ckeCopyBOut
);
  logic [3:0] wake;
  logic       live;

  // saturating, so a long run never wraps back to asleep
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake <= 4'h0;
    end else if (!bufResetN) begin
      wake <= 4'h0;
    end else if (ce && wake != 4'hF) begin
      wake <= wake + 4'h1;
    end
  end
  assign live = (wake == 4'hF);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_open;
    live && !(primarySelectN && secondarySelectN);
  endsequence
  sequence s_shut;
    live && primarySelectN && secondarySelectN;
  endsequence

  a_reset_low: assert property (
    !bufResetN |-> ~|registeredOutputs && ~|registeredOutputsB
    && !selectCopyAOut && !ckeCopyAOut)
    else $error("outputs not low in reset");
  a_legal_modes: assert property (
    pinoutVariantSel |-> widthModeSel)
    else $error("variant select driven without width select");
  a_asleep_low: assert property (wake <= 4'h7 |->
    ~|registeredOutputs && !selectCopyAOut)
    else $error("outputs moved before receivers woke");
  a_direct_copy: assert property (
    s_open ##0 !widthModeSel |=>
    registeredOutputs == $past(gatedDataInputs) && ~|registeredOutputsB)
    else $error("direct mode output wrong");
  a_gated_hold: assert property (s_shut |=>
    $stable(registeredOutputs) && $stable(registeredOutputsB))
    else $error("gated outputs changed");
  a_copies_live: assert property (live |=>
    selectCopyAOut == $past(primarySelectN)
    && terminationCopyAOut == $past(terminationCtrlIn)
    && ckeCopyAOut == $past(clockEnableCtrlIn))
    else $error("ungated copy wrong");
  a_variant_a: assert property (
    s_open ##0 (widthModeSel && !pinoutVariantSel) |=>
    registeredOutputs == {11'h000, $past(gatedDataInputs[13:0])})
    else $error("variant A output wrong");
  a_variant_b: assert property (
    s_open ##0 (widthModeSel && pinoutVariantSel) |=>
    registeredOutputs == {11'h000, $past(gatedDataInputs[24:11])})
    else $error("variant B output wrong");
  a_twin_copies: assert property (s_open ##0 widthModeSel |=>
    registeredOutputsB == registeredOutputs[13:0]
    && selectCopyBOut == selectCopyAOut
    && terminationCopyBOut == terminationCopyAOut
    && ckeCopyBOut == ckeCopyAOut)
    else $error("B copy differs from A copy");
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: drives controller software port, judges buffer outputs
// Assumes: both ends joined by one link interface
// Notes:   expectations built from word layout and register map
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk;
  logic        arst_n;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        ce;
  int          miscompares = 0;
  int          cmpCount = 0;
  int          cyc = 0;

  rdb_link_if link ();
  rdb_controller i_rdb_controller (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .link(link.ctl));
  rdb_buffer i_rdb_buffer (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .link(link.dev));
  rdb_properties i_rdb_properties (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .gatedDataInputs(link.gatedDataInputs),
    .primarySelectN(link.primarySelectN),
    .secondarySelectN(link.secondarySelectN),
    .terminationCtrlIn(link.terminationCtrlIn),
    .clockEnableCtrlIn(link.clockEnableCtrlIn),
    .widthModeSel(link.widthModeSel), .bufResetN(link.bufResetN),
    .pinoutVariantSel(link.pinoutVariantSel),
    .registeredOutputs(link.registeredOutputs),
    .registeredOutputsB(link.registeredOutputsB),
    .selectCopyAOut(link.selectCopyAOut),
    .selectCopyBOut(link.selectCopyBOut),
    .terminationCopyAOut(link.terminationCopyAOut),
    .terminationCopyBOut(link.terminationCopyBOut),
    .ckeCopyAOut(link.ckeCopyAOut), .ckeCopyBOut(link.ckeCopyBOut));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic chkrd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  function automatic logic [31:0] wd(logic [24:0] d, logic ps, logic ss);
    return {5'h00, ss, ps, d};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chkrd(rdb_pkg::OFS_OBS_A, 32'h00000000);
    chkrd(rdb_pkg::OFS_OBS_B, 32'h00000000);
    chkrd(rdb_pkg::OFS_IDLE, 32'h06000000);
    $display("t_reset done");
  endtask
  task automatic t_gate();
    wr(rdb_pkg::OFS_IDLE, 32'h1E000000);
    wr(rdb_pkg::OFS_CTRL, 32'h00000009);
    repeat (20) @(posedge mclk);
    wr(rdb_pkg::OFS_DATA, wd(25'h1ABCDEF, 1'b0, 1'b1));
    wr(rdb_pkg::OFS_DATA, wd(25'h0123456, 1'b1, 1'b1));
    repeat (4) @(posedge mclk);
    chkrd(rdb_pkg::OFS_OBS_A, 32'h01ABCDEF);
    chkrd(rdb_pkg::OFS_OBS_B, 32'h00054000);
    wr(rdb_pkg::OFS_DATA, wd(25'h0123456, 1'b1, 1'b0));
    repeat (4) @(posedge mclk);
    chkrd(rdb_pkg::OFS_OBS_A, 32'h00123456);
    $display("t_gate done");
  endtask
  task automatic t_fifo();
    wr(rdb_pkg::OFS_CTRL, 32'h00000008);
    for (int i = 0; i < 17; i++) begin
      wr(rdb_pkg::OFS_DATA, wd(25'(i + 32'h100), 1'b0, 1'b0));
    end
    chkrd(rdb_pkg::OFS_STATUS, 32'h00000102);
    wr(rdb_pkg::OFS_CTRL, 32'h00000009);
    repeat (25) @(posedge mclk);
    chkrd(rdb_pkg::OFS_STATUS, 32'h00000101);
    chkrd(rdb_pkg::OFS_OBS_A, 32'h0000010F);
    $display("t_fifo done");
  endtask
  task automatic t_split();
    logic [24:0] z;
    logic [31:0] e;
    z = 25'h1555AAA;
    // variant asked without width must still come out 1:1
    wr(rdb_pkg::OFS_CTRL, 32'h0000000D);
    wr(rdb_pkg::OFS_DATA, wd(z, 1'b0, 1'b0));
    repeat (4) @(posedge mclk);
    chkrd(rdb_pkg::OFS_OBS_A, {7'h00, z});
    chkrd(rdb_pkg::OFS_OBS_B, 32'h00054000);
    for (int v = 0; v < 2; v++) begin
      wr(rdb_pkg::OFS_CTRL, (v == 1) ? 32'h0000000F : 32'h0000000B);
      wr(rdb_pkg::OFS_DATA, wd(z, 1'b0, 1'b0));
      repeat (4) @(posedge mclk);
      e = (v == 1) ? {18'h00000, z[24:11]} : {18'h00000, z[13:0]};
      chkrd(rdb_pkg::OFS_OBS_A, e);
      chkrd(rdb_pkg::OFS_OBS_B, 32'h000FC000 | e);
    end
    $display("t_split done");
  endtask
  task automatic t_unmapped();
    wr(8'h18, 32'hFFFFFFFF);
    chkrd(8'h18, 32'h00000000);
    $display("t_unmapped done");
  endtask
  // enable low: nothing taken, read data and outputs frozen
  task automatic t_freeze();
    @(posedge mclk);
    ce <= 1'b0;
    wr(rdb_pkg::OFS_DATA, wd(25'h1FFFFFF, 1'b0, 1'b0));
    chkrd(rdb_pkg::OFS_STATUS, 32'h00000000);
    @(posedge mclk);
    ce <= 1'b1;
    chkrd(rdb_pkg::OFS_STATUS, 32'h00000101);
    chkrd(rdb_pkg::OFS_OBS_A, 32'h00002AAB);
    $display("t_freeze done");
  endtask
  // reset lands between edges, outputs held and nonzero before it
  task automatic t_midreset();
    @(posedge mclk);
    #7 arst_n = 1'b0;
    #3;
    chk({7'h00, link.registeredOutputs}, 32'h00000000);
    chk({18'h00000, link.registeredOutputsB}, 32'h00000000);
    repeat (3) @(posedge mclk);
    #5 arst_n = 1'b1;
    t_reset();
    $display("t_midreset done");
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    arst_n    = 1'b0;
    ce        = 1'b1;
    regWr     = 1'b0;
    regRd     = 1'b0;
    regAddr   = 8'h00;
    regWrData = 32'h00000000;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_gate();
    t_fifo();
    t_split();
    t_unmapped();
    t_freeze();
    t_midreset();
    print_verdict();
  end
endmodule
`default_nettype wire
